// ---- ifp_pkg.sv ----
/*
  Shared constants and types for the interframe prediction unit and its
  partner end. Assumes 8-bit pixels, 8x8 blocks and six blocks per
  macroblock (four luminance, then two chrominance).
*/
package ifp_pkg;
  localparam int PIX_W = 8;
  localparam int DCT_W = 9;
  localparam int ENERGY_W = 24;
  localparam int FIFO_DEPTH = 32;
  localparam real CLOCK_PERIOD_NS = 50.0;
  localparam logic [5:0] FIRST_IDX = 6'h00;
  localparam logic [5:0] LAST_IDX = 6'h3f;
  localparam logic [2:0] LAST_BLK = 3'h5;
  localparam logic [2:0] LUMA_BLKS = 3'h4;
  localparam logic [2:0] ROW_FIRST = 3'h0;
  localparam logic [2:0] ROW_LAST = 3'h7;
  localparam logic [8:0] MID_GRAY = 9'h080;
  localparam logic [9:0] FILT_ROUND = 10'h002;
  localparam logic [9:0] PIX_MAX = 10'h0ff;
  localparam logic [8:0] MB_LAST = 9'h17f;

  typedef enum logic [1:0]
  {
    IFP_FILL = 2'b01,
    IFP_EMIT = 2'b10
  } ifp_state_e;
endpackage : ifp_pkg

// ---- ifp_if.sv ----
/*
  Link between the prediction unit (dev) and its partner end (host).
  Assumes both ends run on one common clock supplied to each module.
*/
`timescale 1ns/1ps
interface ifp_if;
  logic mode_decoder;
  logic blk_mc;
  logic blk_ext_intra;
  logic in_valid;
  logic in_ready;
  logic [7:0] cur_frame_pix_in;
  logic [7:0] prev_frame_pix_in;
  logic dct_valid;
  logic dct_ready;
  logic [8:0] pred_pix_to_dct;
  logic idct_valid;
  logic idct_ready;
  logic [8:0] idct_sample;
  logic recon_valid;
  logic recon_ready;
  logic [7:0] recon_pix_out;

  modport dev
  (
    input mode_decoder, blk_mc, blk_ext_intra, in_valid,
    input cur_frame_pix_in, prev_frame_pix_in, dct_ready,
    input idct_valid, idct_sample, recon_ready,
    output in_ready, dct_valid, pred_pix_to_dct, idct_ready,
    output recon_valid, recon_pix_out
  );

  modport host
  (
    output mode_decoder, blk_mc, blk_ext_intra, in_valid,
    output cur_frame_pix_in, prev_frame_pix_in, dct_ready,
    output idct_valid, idct_sample, recon_ready,
    input in_ready, dct_valid, pred_pix_to_dct, idct_ready,
    input recon_valid, recon_pix_out
  );
endinterface : ifp_if

// ---- ifp_dev.sv ----
/*
  Interframe prediction unit: prediction FIFO and the device end.
  Assumes the partner keeps the link handshakes and returns one inverse
  transform sample per pixel sent out, in the same order.
  // Summary of operation
  // - Loop filter previous pixels only when compensated
  // - Encoder compares intra and difference energies
  // - Lower-energy candidate goes to transform
  // - Reconstruct as prediction plus inverse transform
  // - Decoder takes intra choice from outside
  // - Latency to inverse transform matched internally
  // - Current pixels arrive 8-bit, raster blocks
  // - Previous pixels arrive 8-bit, same order
  // - Reconstructed 8-bit pixels refresh frame store
  // - Nine-bit signed data toward transform
  // - Bit zero is least significant
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module ifp_fifo
  import ifp_pkg::*;
#(
  parameter int WIDTH = PIX_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } ifp_fifo_s;

  ifp_fifo_s r;
  ifp_fifo_s next_r;
  logic push;
  logic pop;

  assign in_ready = r.cnt != (AW+1)'(DEPTH);
  assign out_valid = r.cnt != '0;
  assign out_data = r.mem[r.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap naturally, so DEPTH must be a power of two
  always_comb
  begin
    next_r = r;
    if (push)
    begin
      next_r.mem[r.wr] = in_data;
      next_r.wr = r.wr + 1'b1;
    end
    if (pop)
      next_r.rd = r.rd + 1'b1;
    if (push && !pop)
      next_r.cnt = r.cnt + 1'b1;
    else if (pop && !push)
      next_r.cnt = r.cnt - 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end
endmodule : ifp_fifo

////////////////////////////////////////////////////////////////////////////
module ifp_dev
  import ifp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  output logic intra_flag,
  output logic [2:0] blk_num,
  ifp_if.dev lnk
);
  typedef struct packed
  {
    ifp_state_e state;
    logic [5:0] idx;
    logic [2:0] blk;
    logic filt_en;
    logic intra;
    logic dec;
    logic [ENERGY_W-1:0] e_intra;
    logic [ENERGY_W-1:0] e_inter;
    logic [63:0][7:0] cur_mem;
    logic [63:0][7:0] prev_mem;
    logic dct_valid;
    logic [8:0] dct_data;
    logic recon_valid;
    logic [7:0] recon;
  } ifp_dev_s;

  ifp_dev_s r;
  ifp_dev_s next_r;
  logic take;
  logic emit;
  logic [7:0] pred;
  logic signed [19:0] d_intra;
  logic signed [19:0] d_inter;
  logic [19:0] sq_intra;
  logic [19:0] sq_inter;
  logic [ENERGY_W-1:0] ei_sum;
  logic [ENERGY_W-1:0] ee_sum;
  logic signed [9:0] rsum;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_pred;
  logic rec_go;

  // Horizontal [1 2 1]/4 along each block row; row ends pass through
  function automatic logic [7:0] ifp_filt(input logic [63:0][7:0] m,
                                         input logic [5:0] i,
                                         input logic en);
    logic [9:0] s;
    s = {2'b00, m[i - 6'h01]} + {1'b0, m[i], 1'b0} +
        {2'b00, m[i + 6'h01]} + FILT_ROUND;
    if (!en || i[2:0] == ROW_FIRST || i[2:0] == ROW_LAST)
      return m[i];
    return s[9:2];
  endfunction : ifp_filt

  ////////////////////////////////////////////////////////////////////////
  assign lnk.in_ready = r.state == IFP_FILL;
  assign take = lnk.in_valid && r.state == IFP_FILL;
  assign emit = r.state == IFP_EMIT && fifo_in_ready &&
                (!r.dct_valid || lnk.dct_ready);
  assign pred = r.intra ? '0 : ifp_filt(r.prev_mem, r.idx, r.filt_en);

  // Energies on bit 0 = LSB pixel values
  assign d_intra = 20'($signed({2'b00, lnk.cur_frame_pix_in})) -
                   20'($signed({1'b0, MID_GRAY}));
  assign d_inter = 20'($signed({2'b00, lnk.cur_frame_pix_in})) -
                   20'($signed({2'b00, lnk.prev_frame_pix_in}));
  assign sq_intra = d_intra * d_intra;
  assign sq_inter = d_inter * d_inter;
  assign ei_sum = (r.idx == FIRST_IDX ? '0 : r.e_intra) +
                  ENERGY_W'(sq_intra);
  assign ee_sum = (r.idx == FIRST_IDX ? '0 : r.e_inter) +
                  ENERGY_W'(sq_inter);

  assign rsum = $signed({2'b00, fifo_pred}) +
                $signed({lnk.idct_sample[8], lnk.idct_sample});
  assign rec_go = fifo_out_valid && lnk.idct_valid &&
                  (!r.recon_valid || lnk.recon_ready);
  assign lnk.idct_ready = fifo_out_valid &&
                          (!r.recon_valid || lnk.recon_ready);

  assign lnk.dct_valid = r.dct_valid;
  assign lnk.pred_pix_to_dct = r.dct_data;
  assign lnk.recon_valid = r.recon_valid;
  assign lnk.recon_pix_out = r.recon;
  assign intra_flag = r.intra;
  assign blk_num = r.blk;

  ////////////////////////////////////////////////////////////////////////
  // Predictions wait here until the matching inverse sample returns
  ifp_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_pred_fifo
  (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(emit),
    .in_ready(fifo_in_ready),
    .in_data(pred),
    .out_valid(fifo_out_valid),
    .out_ready(rec_go),
    .out_data(fifo_pred)
  );

  always_comb
  begin
    next_r = r;
    case (r.state)
      IFP_FILL:
      begin
        if (take)
        begin
          next_r.cur_mem[r.idx] = lnk.cur_frame_pix_in;
          next_r.prev_mem[r.idx] = lnk.prev_frame_pix_in;
          next_r.e_intra = ei_sum;
          next_r.e_inter = ee_sum;
          next_r.idx = r.idx + 1'b1;
          if (r.idx == FIRST_IDX)
          begin
            next_r.filt_en = lnk.blk_mc;
            // Mode kept per block: the next macroblock may change it early
            next_r.dec = lnk.mode_decoder;
            if (lnk.mode_decoder)
              next_r.intra = lnk.blk_ext_intra;
          end
          if (r.idx == LAST_IDX)
          begin
            // In encoder mode, chroma blocks keep the decision of the last luma block
            if (!r.dec && r.blk < LUMA_BLKS)
              next_r.intra = ei_sum < ee_sum;
            next_r.state = IFP_EMIT;
          end
        end
      end
      IFP_EMIT:
      begin
        if (emit)
        begin
          next_r.dct_valid = 1'b1;
          if (r.dec)
            next_r.dct_data = '0;
          else
            next_r.dct_data = {1'b0, r.cur_mem[r.idx]} -
                              {1'b0, pred};
          next_r.idx = r.idx + 1'b1;
          if (r.idx == LAST_IDX)
          begin
            next_r.state = IFP_FILL;
            next_r.blk = r.blk == LAST_BLK ? '0 : r.blk + 1'b1;
          end
        end
        else if (lnk.dct_ready)
          next_r.dct_valid = 1'b0;
      end
      default:
        next_r.state = IFP_FILL;
    endcase
    if (r.state == IFP_FILL && lnk.dct_ready)
      next_r.dct_valid = 1'b0;

    if (rec_go)
    begin
      next_r.recon_valid = 1'b1;
      if (rsum < 0)
        next_r.recon = '0;
      else if (rsum > $signed(PIX_MAX))
        next_r.recon = PIX_MAX[7:0];
      else
        next_r.recon = rsum[7:0];
    end
    else if (lnk.recon_ready)
      next_r.recon_valid = 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.state <= IFP_FILL;
    end
    else
      r <= next_r;
  end
endmodule : ifp_dev

// ---- ifp_host.sv ----
/*
  Partner end of the prediction unit: feeds pixels and block flags,
  hands transform data to the user and returns inverse samples.
  Assumes the user side keeps valid/ready handshakes.
*/
`timescale 1ns/1ps
module ifp_host
  import ifp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic user_mode_decoder,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [7:0] src_cur,
  input wire logic [7:0] src_prev,
  input wire logic src_mc,
  input wire logic src_ext_intra,
  output logic dct_out_valid,
  input wire logic dct_out_ready,
  output logic [8:0] dct_out,
  input wire logic idct_in_valid,
  output logic idct_in_ready,
  input wire logic [8:0] idct_in,
  output logic recon_valid,
  input wire logic recon_ready,
  output logic [7:0] recon,
  ifp_if.host lnk
);
  typedef struct packed
  {
    logic mode;
    logic [8:0] mb_cnt;
    logic in_valid;
    logic [7:0] cur;
    logic [7:0] prev;
    logic mc;
    logic ext_intra;
    logic idct_valid;
    logic [8:0] idct;
  } ifp_host_s;

  ifp_host_s r;
  ifp_host_s next_r;
  logic src_take;

  assign src_ready = !r.in_valid || lnk.in_ready;
  assign src_take = src_valid && src_ready;
  assign idct_in_ready = !r.idct_valid || lnk.idct_ready;

  assign lnk.mode_decoder = r.mode;
  assign lnk.in_valid = r.in_valid;
  assign lnk.cur_frame_pix_in = r.cur;
  assign lnk.prev_frame_pix_in = r.prev;
  assign lnk.blk_mc = r.mc;
  assign lnk.blk_ext_intra = r.ext_intra;
  assign lnk.idct_valid = r.idct_valid;
  assign lnk.idct_sample = r.idct;
  assign lnk.dct_ready = dct_out_ready;
  assign dct_out_valid = lnk.dct_valid;
  assign dct_out = lnk.pred_pix_to_dct;
  assign lnk.recon_ready = recon_ready;
  assign recon_valid = lnk.recon_valid;
  assign recon = lnk.recon_pix_out;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_r = r;
    if (src_take)
    begin
      next_r.in_valid = 1'b1;
      next_r.cur = src_cur;
      next_r.prev = src_prev;
      next_r.mc = src_mc;
      next_r.ext_intra = src_ext_intra;
      next_r.mb_cnt = r.mb_cnt == MB_LAST ? '0 : r.mb_cnt + 1'b1;
      // Mode changes only at a macroblock's first pixel
      if (r.mb_cnt == '0)
        next_r.mode = user_mode_decoder;
    end
    else if (lnk.in_ready)
      next_r.in_valid = 1'b0;
    if (idct_in_valid && idct_in_ready)
    begin
      next_r.idct_valid = 1'b1;
      next_r.idct = idct_in;
    end
    else if (lnk.idct_ready)
      next_r.idct_valid = 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end
endmodule : ifp_host

// ---- ifp_chk.sv ----
/*
  Checker on the link between the two ends of the prediction unit.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module ifp_chk
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic dct_valid,
  input wire logic dct_ready,
  input wire logic [8:0] pred_pix_to_dct,
  input wire logic idct_valid,
  input wire logic idct_ready,
  input wire logic recon_valid,
  input wire logic recon_ready,
  input wire logic [7:0] recon_pix_out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic [5:0] pix;
  logic [7:0] lowc;
  int pend;
  logic idct_take;
  assign idct_take = idct_valid && idct_ready;
  // Pixels into the block, closed-input cycles, samples not yet returned
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pix <= 6'h00;
      lowc <= 8'h00;
      pend <= '0;
    end
    else
    begin
      pix <= pix + 6'(in_valid && in_ready);
      lowc <= in_ready ? 8'h00 : lowc + 8'(lowc != 8'hff);
      pend <= pend + int'(dct_valid && dct_ready) - int'(idct_take);
    end
  end
  //////////////////////////////////////////////////////////////
  fill_end_a:
    assert property (in_valid && in_ready && pix == 6'h3f |=> !in_ready)
    else $error("input open after a full block");
  emit_len_a:
    assert property ($rose(in_ready) |-> lowc >= 8'h40)
    else $error("input reopened before 64 outputs");
  dct_hold_a:
    assert property (dct_valid && !dct_ready |=>
      dct_valid && $stable(pred_pix_to_dct))
    else $error("transform data dropped while stalled");
  recon_hold_a:
    assert property (recon_valid && !recon_ready |=>
      recon_valid && $stable(recon_pix_out))
    else $error("rebuilt pixel dropped while stalled");
  recon_answer_a:
    assert property (idct_take |=> recon_valid)
    else $error("no rebuilt pixel after a sample");
  recon_cause_a:
    assert property ($rose(recon_valid) |-> $past(idct_take))
    else $error("rebuilt pixel without a sample");
  recon_slot_a:
    assert property (idct_ready |-> !recon_valid || recon_ready)
    else $error("sample taken with output slot full");
  pend_range_a:
    assert property (pend <= 32 && (!idct_take || pend >= 0))
    else $error("returned samples out of step");
endmodule : ifp_chk

// ---- tb_interframe_prediction_unit.sv ----
/*
  Bench joining both ends over the link, driving their user side.
  Assumes random samples may stand in for the inverse transform.
*/
`timescale 1ns/1ps
module tb_interframe_prediction_unit
  import ifp_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic user_mode_decoder = 1'b0;
  logic src_valid = 1'b0;
  logic [7:0] src_cur = 8'h00;
  logic [7:0] src_prev = 8'h00;
  logic src_mc = 1'b0;
  logic src_ext_intra = 1'b0;
  logic dct_out_ready = 1'b0;
  logic idct_in_valid = 1'b0;
  logic [8:0] idct_in = 9'h000;
  logic recon_ready = 1'b0;
  logic src_ready, dct_out_valid, idct_in_ready, recon_valid;
  logic [8:0] dct_out;
  logic [7:0] recon;
  logic [8:0] q_dct[$];
  logic [8:0] q_pred[$];
  logic [8:0] q_rec[$];
  logic [8:0] q_blk[$];
  logic intra_flag;
  logic [2:0] blk_num;
  logic in_fill = 1'b1;
  int fails = 0;
  int n_compared = 0;
  int seed = 56063;

  always #25 clock = ~clock;

  ifp_if lnk ();
  ifp_dev ifp_dev_i (.clock, .rst_n, .intra_flag, .blk_num, .lnk);
  ifp_host ifp_host_i (.clock, .rst_n, .user_mode_decoder, .src_valid,
    .src_ready, .src_cur, .src_prev, .src_mc, .src_ext_intra, .dct_out_valid,
    .dct_out_ready, .dct_out, .idct_in_valid, .idct_in_ready, .idct_in,
    .recon_valid, .recon_ready, .recon, .lnk);
  ifp_chk ifp_chk_i (.clock, .rst_n, .in_valid(lnk.in_valid),
    .in_ready(lnk.in_ready), .dct_valid(lnk.dct_valid),
    .dct_ready(lnk.dct_ready), .pred_pix_to_dct(lnk.pred_pix_to_dct),
    .idct_valid(lnk.idct_valid), .idct_ready(lnk.idct_ready),
    .recon_valid(lnk.recon_valid), .recon_ready(lnk.recon_ready),
    .recon_pix_out(lnk.recon_pix_out));

  //////////////////////////////////////////////////////////////
  task chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task tally_and_finish;
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // Odd blocks sit near mid-gray, even ones track the previous frame
  task run_mb(input logic dec);
    logic [7:0] c[64];
    logic [7:0] p[64];
    logic [7:0] f[64];
    logic mc, intra;
    int ei, ee;
    for (int b = 0; b < 6; b++)
    begin
      mc = 1'($random(seed));
      ei = 0;
      ee = 0;
      for (int i = 0; i < 64; i++)
      begin
        c[i] = b % 2 ? 8'h78 + 8'($random(seed) & 15) : 8'($random(seed));
        p[i] = b % 2 ? 8'($random(seed)) : c[i] ^ 8'($random(seed) & 7);
        ei += (c[i] - 128) * (c[i] - 128);
        ee += (c[i] - p[i]) * (c[i] - p[i]);
      end
      if (b < 4)
        intra = ei < ee;
      if (dec)
        intra = 1'($random(seed));
      q_blk.push_back({5'h00, 3'(b), intra});
      for (int i = 0; i < 64; i++)
      begin
        f[i] = mc && i % 8 != 0 && i % 8 != 7 ?
          8'((p[i-1] + 2 * p[i] + p[i+1] + 2) >> 2) : p[i];
        q_pred.push_back(intra ? 9'h000 : {1'b0, f[i]});
        q_dct.push_back(dec ? 9'h000 : {1'b0, c[i]} - q_pred[$]);
      end
      for (int i = 0; i < 64; i++)
      begin
        user_mode_decoder <= dec;
        src_valid <= 1'b1;
        src_cur <= c[i];
        src_prev <= p[i];
        src_mc <= mc;
        // Encoder is handed the opposite choice, which it must ignore
        src_ext_intra <= dec ? intra : !intra;
        @(posedge clock);
        while (src_ready !== 1'b1)
          @(posedge clock);
      end
    end
  endtask : run_mb

  always @(posedge clock)
  begin : idct_drv
    logic go;
    logic [8:0] s;
    int r;
    if (rst_n && (idct_in_valid !== 1'b1 || idct_in_ready === 1'b1))
    begin
      go = q_pred.size() > 0 && ($random(seed) & 3) != 0;
      idct_in_valid <= go;
      if (go)
      begin
        s = 9'($random(seed));
        r = int'(q_pred.pop_front()) + int'(signed'(s));
        q_rec.push_back(r < 0 ? 9'h000 : r > 255 ? 9'h0ff : 9'(r));
        idct_in <= s;
      end
    end
  end

  // Random stalls on both outputs keep the prediction queue busy
  always @(posedge clock)
  begin
    dct_out_ready <= 1'($random(seed));
    recon_ready <= ($random(seed) & 3) != 0;
    if (dct_out_valid === 1'b1 && dct_out_ready === 1'b1)
      chk("dct", dct_out, q_dct.pop_front());
    if (recon_valid === 1'b1 && recon_ready === 1'b1)
      chk("recon", {1'b0, recon}, q_rec.pop_front());
    // Block number and decision checked once, at the start of each emit phase
    if (lnk.in_ready === 1'b0 && in_fill)
      chk("block", {5'h00, blk_num, intra_flag}, q_blk.pop_front());
    in_fill = lnk.in_ready === 1'b1;
  end

  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    run_mb(1'b0);
    run_mb(1'b1);
    run_mb(1'b0);
    src_valid <= 1'b0;
    while (q_dct.size() + q_pred.size() + q_rec.size() + q_blk.size() > 0)
      @(posedge clock);
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    tally_and_finish();
  end
endmodule : tb_interframe_prediction_unit
